//--- acsc_pkg.sv
package acsc_pkg;

    localparam int CLK_MHZ            = 250;
    localparam int FG_CAL_TIME_US     = 100;
    localparam int OFFSET_CAL_ENABLE_TIME_US     = 20;
    localparam int BG_CAL_TIME_US     = 50;
    localparam int FG_CAL_CYCLES_DEF  = FG_CAL_TIME_US * CLK_MHZ;
    localparam int OFFSET_CAL_ENABLE_CYCLES_DEF  = OFFSET_CAL_ENABLE_TIME_US * CLK_MHZ;
    localparam int BG_CAL_CYCLES_DEF  = BG_CAL_TIME_US * CLK_MHZ;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL       = 10'h000;
    localparam logic [9:0] IDX_STATUS     = 10'h001;
    localparam logic [9:0] IDX_INT_STATUS = 10'h002;
    localparam logic [9:0] IDX_INT_MASK   = 10'h003;
    localparam logic [9:0] IDX_TRIM0      = 10'h010;
    localparam logic [9:0] IDX_SRC_DLY    = 10'h09a;
    localparam logic [9:0] IDX_MUX_DLY    = 10'h09b;

    // control bits
    localparam int CTRL_TRIG_SEL  = 0;
    localparam int CTRL_SOFT_TRIG = 1;
    localparam int CTRL_BG_EN     = 2;
    localparam int CTRL_OS_EN     = 3;
    localparam int CTRL_BGOS_EN   = 4;
    localparam int CTRL_WIDTH     = 5;

    // interrupt status bits
    localparam int INT_FOREGROUND_DONE_FLAG    = 0;
    localparam int INT_SWAP       = 1;
    localparam int INT_TRIG_IGN   = 2;
    localparam int INT_WIDTH      = 3;

    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
    localparam logic [INT_WIDTH-1:0]  INT_RESET  = 3'h0;
    localparam logic [7:0]            DLY_RESET  = 8'h00;
    localparam logic [8:0]            MID_CODE   = 9'h000;
    localparam logic [5:0]            ALL_CORES  = 6'h3f;

    // foreground core assignment and spares
    localparam logic [2:0] CORE_CH_A = 3'h0;
    localparam logic [2:0] CORE_CH_B = 3'h1;
    localparam logic [2:0] CORE_CH_C = 3'h4;
    localparam logic [2:0] CORE_CH_D = 3'h5;
    localparam logic [2:0] SPARE_G0  = 3'h2;
    localparam logic [2:0] SPARE_G1  = 3'h3;

    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_FG        = 5'h02,
        ST_BG_CAL    = 5'h04,
        ST_BG_SWAP   = 5'h08,
        ST_BG_SETTLE = 5'h10
    } acsc_state_type;

endpackage : acsc_pkg

//--- acsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acsc_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic async_in,
    output logic      sync_out
);
    import acsc_pkg::*;

    logic meta;

    // meta feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : acsc_sync
`default_nettype wire

//--- acsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module acsc_top #(
    parameter int         CHANNELS      = 4,
    parameter logic [15:0] FG_CAL_CYCLES = 16'(acsc_pkg::FG_CAL_CYCLES_DEF),
    parameter logic [15:0] OFFSET_CAL_ENABLE_CYCLES = 16'(acsc_pkg::OFFSET_CAL_ENABLE_CYCLES_DEF),
    parameter logic [15:0] BG_CAL_CYCLES = 16'(acsc_pkg::BG_CAL_CYCLES_DEF)
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_cal_trigger_pin,
    input  wire logic [5:0][8:0]   core_data,
    input  wire logic [5:0][23:0]  factory_trim,
    output logic      [3:0][8:0]   chan_data,
    output logic      [5:0]        core_cal_en,
    output logic                   offset_cal_active,
    output logic      [5:0][23:0]  trim_value,
    output logic                   irq
);
    import acsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    acsc_state_type              state;
    acsc_state_type              next_state;
    logic [15:0]                 cnt;
    logic [CTRL_WIDTH-1:0]       ctrl;
    logic [INT_WIDTH-1:0]        int_status;
    logic [INT_WIDTH-1:0]        int_mask;
    logic [7:0]                  core_source_switch_delay;
    logic [7:0]                  mux_select_switch_delay;
    logic                        foreground_done_flag;
    logic [3:0][2:0]             chan_map;
    logic [2:0]                  off0;
    logic [2:0]                  off1;
    logic                        tgl0;
    logic                        tgl1;
    logic                        grp;
    logic                        trig_q;
    logic                        pin_sync;

    acsc_sync u_pin_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (external_cal_trigger_pin),
        .sync_out (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection and decode
    wire        trigger_source_select        = ctrl[CTRL_TRIG_SEL];
    wire        software_cal_trigger         = ctrl[CTRL_SOFT_TRIG];
    wire        background_cal_enable        = ctrl[CTRL_BG_EN];
    wire        offset_cal_enable            = ctrl[CTRL_OS_EN];
    wire        background_offset_cal_enable = ctrl[CTRL_BGOS_EN];
    wire        sel_trig   = trigger_source_select ? pin_sync : software_cal_trigger;
    wire        trig_edge  = sel_trig & ~trig_q;
    wire        bg_go      = background_cal_enable & ~trigger_source_select
                             & software_cal_trigger;
    wire        in_fg      = (state == ST_FG);
    wire        in_bg      = (state == ST_BG_CAL) | (state == ST_BG_SWAP)
                             | (state == ST_BG_SETTLE);
    wire [15:0] fg_limit   = 16'(FG_CAL_CYCLES + (offset_cal_enable ? OFFSET_CAL_ENABLE_CYCLES
                                                                    : 16'h0000));
    wire        fg_end     = in_fg & (cnt >= fg_limit - 16'h0001);
    wire        bg_cal_end = (cnt >= BG_CAL_CYCLES - 16'h0001);
    wire        src_done   = (cnt >= {8'h00, core_source_switch_delay});
    wire        mux_done   = (cnt >= {8'h00, mux_select_switch_delay});
    wire        swap_now   = (state == ST_BG_SWAP) & src_done;
    wire        fg_start   = (state == ST_IDLE) & trig_edge;
    wire        trig_ign   = in_fg & trig_edge;
    wire        use_g1     = (CHANNELS == 4) & grp;
    wire [2:0]  cal_core   = use_g1 ? off1 : off0;
    wire [1:0]  tch0       = (CHANNELS == 1 || !tgl0) ? 2'h0 : 2'h1;
    wire [1:0]  tch1       = tgl1 ? 2'h3 : 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // calibration sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trig_edge) begin
                    next_state = ST_FG;
                end
            end
            ST_FG: begin
                if (fg_end) begin
                    next_state = bg_go ? ST_BG_CAL : ST_IDLE;
                end
            end
            ST_BG_CAL: begin
                if (!bg_go) begin
                    next_state = ST_IDLE;
                end else if (bg_cal_end) begin
                    next_state = ST_BG_SWAP;
                end
            end
            ST_BG_SWAP: begin
                if (src_done) begin
                    next_state = ST_BG_SETTLE;
                end
            end
            ST_BG_SETTLE: begin
                if (mux_done) begin
                    next_state = bg_go ? ST_BG_CAL : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // reset lands in the foreground pass so power-up always calibrates
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state  <= ST_FG;
            cnt    <= 16'h0000;
            trig_q <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= (next_state != state) ? 16'h0000 : 16'(cnt + 16'h0001);
            trig_q <= sel_trig;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            foreground_done_flag <= 1'b0;
        end else if (fg_end) begin
            foreground_done_flag <= 1'b1;
        end else if (fg_start) begin
            foreground_done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core rotation
    always_ff @(posedge core_clk) begin
        if (!rstn || fg_start) begin
            chan_map <= {CORE_CH_D, CORE_CH_C, CORE_CH_B, CORE_CH_A};
            off0     <= SPARE_G0;
            off1     <= SPARE_G1;
            tgl0     <= 1'b0;
            tgl1     <= 1'b0;
            grp      <= 1'b0;
        end else if (swap_now) begin
            // the calibrated core takes over; the displaced one goes offline
            if (use_g1) begin
                chan_map[tch1] <= off1;
                off1           <= chan_map[tch1];
                tgl1           <= ~tgl1;
            end else begin
                chan_map[tch0] <= off0;
                off0           <= chan_map[tch0];
                tgl0           <= (CHANNELS != 1) & ~tgl0;
            end
            grp <= (CHANNELS == 4) & ~grp;
        end
    end

    // only one core sees the reference during background work
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            core_cal_en       <= ALL_CORES;
            offset_cal_active <= 1'b0;
        end else begin
            core_cal_en       <= (next_state == ST_FG) ? ALL_CORES :
                                 (next_state == ST_BG_CAL) ? 6'(6'h01 << cal_core) :
                                 6'h00;
            offset_cal_active <= ((next_state == ST_FG) & offset_cal_enable)
                                 | ((next_state == ST_BG_CAL)
                                    & background_offset_cal_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample path; no blanking at swaps, a short disturbance is accepted
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            always_ff @(posedge core_clk) begin
                if (!rstn || ch >= CHANNELS) begin
                    chan_data[ch] <= MID_CODE;
                end else if (in_fg) begin
                    chan_data[ch] <= MID_CODE;
                end else begin
                    chan_data[ch] <= core_data[chan_map[ch]];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state so every answer is registered
    wire [9:0]  idx       = paddr[11:2];
    wire        access    = psel & penable & ~pready;
    // writes land on the completing edge, the one at which the master sees pready
    wire        wr        = psel & penable & pready & pwrite;
    wire        is_trim   = (idx >= IDX_TRIM0) & (idx < IDX_TRIM0 + 10'h006);
    wire [2:0]  trim_sel  = 3'(idx - IDX_TRIM0);
    wire        mapped    = (idx == IDX_CTRL) | (idx == IDX_STATUS)
                            | (idx == IDX_INT_STATUS) | (idx == IDX_INT_MASK)
                            | (idx == IDX_SRC_DLY) | (idx == IDX_MUX_DLY) | is_trim;
    wire [31:0] status_rd = {21'h0, off1, 1'b0, off0, 1'b0, in_bg, in_fg,
                             foreground_done_flag};
    wire [31:0] rd_mux    = (idx == IDX_CTRL)       ? {27'h0, ctrl} :
                            (idx == IDX_STATUS)     ? status_rd :
                            (idx == IDX_INT_STATUS) ? {29'h0, int_status} :
                            (idx == IDX_INT_MASK)   ? {29'h0, int_mask} :
                            (idx == IDX_SRC_DLY)    ? {24'h0, core_source_switch_delay} :
                            (idx == IDX_MUX_DLY)    ? {24'h0, mux_select_switch_delay} :
                            is_trim                 ? {8'h0, trim_value[trim_sel]} :
                            32'h0000_0000;
    wire [INT_WIDTH-1:0] int_events = {trig_ign, swap_now, fg_end};
    wire [INT_WIDTH-1:0] int_clear  = (wr && idx == IDX_INT_STATUS)
                                      ? pwdata[INT_WIDTH-1:0] : INT_RESET;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl                     <= CTRL_RESET;
            int_mask                 <= INT_RESET;
            core_source_switch_delay <= DLY_RESET;
            mux_select_switch_delay  <= DLY_RESET;
        end else if (wr) begin
            if (idx == IDX_CTRL) begin
                ctrl <= pwdata[CTRL_WIDTH-1:0];
            end
            if (idx == IDX_INT_MASK) begin
                int_mask <= pwdata[INT_WIDTH-1:0];
            end
            if (idx == IDX_SRC_DLY) begin
                core_source_switch_delay <= pwdata[7:0];
            end
            if (idx == IDX_MUX_DLY) begin
                mux_select_switch_delay <= pwdata[7:0];
            end
        end
    end

    // a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            int_status <= INT_RESET;
            irq        <= 1'b0;
        end else begin
            int_status <= (int_status & ~int_clear) | int_events;
            irq        <= |(int_status & int_mask);
        end
    end

    // factory trims are loaded while reset is held
    genvar t;
    generate
        for (t = 0; t < 6; t++) begin : g_trim
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    trim_value[t] <= factory_trim[t];
                end else if (wr && is_trim && trim_sel == 3'(t)) begin
                    trim_value[t] <= pwdata[23:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_fg_mid_code: assert property (@(posedge core_clk) disable iff (!rstn)
        in_fg |=> (chan_data == '0))
        else $error("samples not mid-code during foreground pass");

    chk_fg_all_cores: assert property (@(posedge core_clk) disable iff (!rstn)
        (next_state == ST_FG) |=> (core_cal_en == ALL_CORES))
        else $error("not all cores calibrating in foreground");

    chk_one_core_cal: assert property (@(posedge core_clk) disable iff (!rstn)
        !in_fg |-> $onehot0(core_cal_en))
        else $error("more than one core calibrating");

    chk_done_after_fg: assert property (@(posedge core_clk) disable iff (!rstn)
        fg_end |=> foreground_done_flag ##1 (foreground_done_flag || $past(fg_start)))
        else $error("done flag missing after foreground pass");

    chk_retrig_ignore: assert property (@(posedge core_clk) disable iff (!rstn)
        (trig_ign && !fg_end) |=> (in_fg && cnt == $past(cnt) + 16'h0001))
        else $error("trigger restarted a running pass");

    chk_trig_starts: assert property (@(posedge core_clk) disable iff (!rstn)
        fg_start |=> (in_fg && cnt == 16'h0000 && !foreground_done_flag))
        else $error("trigger did not start foreground pass");

    chk_spare_groups: assert property (@(posedge core_clk) disable iff (!rstn)
        (off0 <= 3'h2) && (off1 >= 3'h3) && (off1 <= 3'h5))
        else $error("spare left its core group");

    chk_map_distinct: assert property (@(posedge core_clk) disable iff (!rstn)
        (chan_map[0] != chan_map[1]) && (chan_map[0] != off0) && (chan_map[1] != off0))
        else $error("core serves two roles at once");

    chk_bg_entry: assert property (@(posedge core_clk) disable iff (!rstn)
        (fg_end && bg_go) |=> (state == ST_BG_CAL) ##1 (core_cal_en == 6'(6'h01 << off0)))
        else $error("background did not follow foreground");

endmodule : acsc_top
`default_nettype wire

//--- acsc_trig_host.sv
`timescale 1ns/1ps
`default_nettype none
module acsc_trig_host (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       fire,
    input  wire logic [7:0] pulse_len,
    output logic            external_cal_trigger_pin,
    output logic            busy
);
    // system side of the trigger pin: high for pulse_len cycles per request
    // pulses shorter than the synchroniser depth can be lost, so callers keep them >= 3
    logic [7:0] left;
    assign busy = left != 8'h00;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            left                     <= 8'h00;
            external_cal_trigger_pin <= 1'b0;
        end else if (fire && !busy) begin
            left                     <= pulse_len;
            external_cal_trigger_pin <= 1'b1;
        end else if (busy) begin
            left                     <= left - 8'h01;
            external_cal_trigger_pin <= left > 8'h01;
        end
    end
endmodule : acsc_trig_host
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import acsc_pkg::*;
    logic core_clk, rstn, psel, penable, pwrite, fire, pready, pslverr, irq, os_act, pin, pin_busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] pulse_len;
    logic [5:0] core_cal_en, dual_cal_en;
    logic [5:0][8:0] core_data;
    logic [3:0][8:0] chan_data, dual_data;
    logic [5:0][23:0] factory_trim, trim_value;
    int fails, tests_run;

    acsc_top #(.CHANNELS(4), .FG_CAL_CYCLES(16'h0014), .OFFSET_CAL_ENABLE_CYCLES(16'h0008),
               .BG_CAL_CYCLES(16'h000a)) dut (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_cal_trigger_pin(pin), .core_data(core_data), .factory_trim(factory_trim),
        .chan_data(chan_data), .core_cal_en(core_cal_en), .offset_cal_active(os_act),
        .trim_value(trim_value), .irq(irq));
    acsc_trig_host host (.core_clk(core_clk), .rstn(rstn), .fire(fire), .pulse_len(pulse_len),
        .external_cal_trigger_pin(pin), .busy(pin_busy));
    // dual variant on the same bus and pin, only its far-side outputs are judged
    acsc_top #(.CHANNELS(2), .FG_CAL_CYCLES(16'h0014), .OFFSET_CAL_ENABLE_CYCLES(16'h0008),
               .BG_CAL_CYCLES(16'h000a)) dut_dual (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .external_cal_trigger_pin(pin), .core_data(core_data), .factory_trim(factory_trim),
        .chan_data(dual_data), .core_cal_en(dual_cal_en), .offset_cal_active(),
        .trim_value(), .irq());

    always #2 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [143:0] exp, input logic [143:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb answer", 1'b1, pready);
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    task automatic rd(input logic [9:0] idx, output logic [31:0] d);
        logic e;
        apb(1'b0, idx, 32'h0, d, e);
    endtask : rd

    task automatic wait_status(input int b, input logic v, input int limit);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(IDX_STATUS, d);
            n++;
        end while (d[b] !== v && n < limit);
        check("status bit", v, d[b]);
    endtask : wait_status

    function automatic logic in_grp(input int lo, input logic [8:0] v);
        return v === core_data[lo] || v === core_data[lo+1] || v === core_data[lo+2];
    endfunction : in_grp

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_power_up();
        logic [31:0] d;
        rd(IDX_STATUS, d);
        check("done during pass", 1'b0, d[0]);
        check("pass cal_en", 6'h3f, core_cal_en);
        check("pass mid code", 36'h0, chan_data);
        check("trim reset", factory_trim, trim_value);
        wait_status(0, 1'b1, 40);
        check("lane map", {core_data[5], core_data[4], core_data[1], core_data[0]}, chan_data);
    endtask : s_power_up

    task automatic s_registers();
        logic [31:0] d;
        logic e;
        rd(IDX_SRC_DLY, d);
        check("src dly reset", 32'h0, d);
        wr(IDX_SRC_DLY, 32'hffffff1f);
        wr(IDX_MUX_DLY, 32'h0000001e);
        rd(IDX_SRC_DLY, d);
        check("src dly", 32'h1f, d);
        rd(IDX_MUX_DLY, d);
        check("mux dly", 32'h1e, d);
        apb(1'b1, 10'h3ff, 32'h1, d, e);
        check("unmapped write", 1'b1, e);
        apb(1'b0, 10'h3ff, 32'h0, d, e);
        check("unmapped read", 33'h100000000, {e, d});
        wr(IDX_TRIM0 + 10'h002, 32'hffabcdef);
        check("trim out", 24'habcdef, trim_value[2]);
        check("trim other", factory_trim[3], trim_value[3]);
        rd(IDX_TRIM0 + 10'h002, d);
        check("trim read", 32'habcdef, d);
    endtask : s_registers

    task automatic s_pin_trigger();
        logic [31:0] d;
        int n;
        wr(IDX_INT_STATUS, 32'h7);
        wr(IDX_INT_MASK, 32'h1);
        wr(IDX_CTRL, 32'h3);
        repeat (6) @(posedge core_clk);
        check("soft ignored when pin selected", 1'b0, core_cal_en === 6'h3f);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        n = 0;
        while (core_cal_en !== 6'h3f && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        check("pin starts pass", 6'h3f, core_cal_en);
        @(posedge core_clk);
        pulse_len <= 8'h06;
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        check("pass mid code", 36'h0, chan_data);
        wait_status(0, 1'b1, 40);
        check("pin pulse over", 1'b0, pin_busy);
        rd(IDX_INT_STATUS, d);
        check("done and ignored", 32'h5, d);
        check("irq done", 1'b1, irq);
        repeat (12) @(posedge core_clk);
        rd(IDX_STATUS, d);
        check("no second pass", 2'h1, d[1:0]);
        wr(IDX_INT_STATUS, 32'h1);
        @(posedge core_clk);
        check("irq masked", 1'b0, irq);
        rd(IDX_INT_STATUS, d);
        check("w1c", 32'h4, d);
        wr(IDX_INT_STATUS, 32'h4);
        wr(IDX_CTRL, 32'h0);
    endtask : s_pin_trigger

    task automatic s_background();
        logic [31:0] d;
        logic [5:0] seen, seen_dual;
        logic os_seen;
        int bad_one, bad_map, bad_dual;
        seen = 6'h00;
        seen_dual = 6'h00;
        bad_dual = 0;
        os_seen = 1'b0;
        bad_one = 0;
        bad_map = 0;
        wr(IDX_INT_MASK, 32'h2);
        wr(IDX_CTRL, 32'h0e);
        repeat (40) begin
            @(posedge core_clk);
            os_seen |= os_act;
        end
        check("offset pass", 1'b1, os_seen);
        wait_status(0, 1'b1, 40);
        // swap glitches are not modelled, so every sample must come from its group
        repeat (1000) begin
            @(posedge core_clk);
            seen |= core_cal_en;
            seen_dual |= dual_cal_en;
            if ($countones(core_cal_en) > 1) bad_one++;
            // dual variant: one shared spare, upper channels stay mid-code
            if ((dual_cal_en & 6'h38) !== 6'h00 || dual_data[3:2] !== 18'h0
                || !in_grp(0, dual_data[0]) || !in_grp(0, dual_data[1])) bad_dual++;
            if (!(in_grp(0, chan_data[0]) && in_grp(0, chan_data[1]) && in_grp(3, chan_data[2])
                  && in_grp(3, chan_data[3])) || chan_data[0] === chan_data[1]
                  || chan_data[2] === chan_data[3]) bad_map++;
        end
        check("one core calibrated", 0, bad_one);
        check("lanes in group", 0, bad_map);
        check("rotation", 6'h3f, seen);
        check("dual lanes", 0, bad_dual);
        check("dual rotation", 6'h07, seen_dual);
        check("swap irq", 1'b1, irq);
        rd(IDX_STATUS, d);
        check("offline groups", 1'b1, d[6:4] <= 3'h2 && d[10:8] >= 3'h3 && d[10:8] <= 3'h5);
        wr(IDX_CTRL, 32'h0);
        wait_status(2, 1'b0, 40);
    endtask : s_background

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fire = 1'b0;
        pulse_len = 8'h03;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 6; i++) begin
            core_data[i] = 9'h041 + 9'(i);
            factory_trim[i] = 24'h102030 + 24'(i);
        end
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        s_power_up();
        s_registers();
        s_pin_trigger();
        s_background();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
